// ==== hdl/fsp_regs.svh ====
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// Register byte offsets on the APB.
`define FSP_CTRL_OFS   8'h00
`define FSP_PTR_OFS    8'h04
`define FSP_DATA_OFS   8'h08
`define FSP_STORE_OFS  8'h0C
`define FSP_LOAD_OFS   8'h10
`define FSP_TRIM_OFS   8'h14
`define FSP_STAT_OFS   8'h18
`define FSP_CLR_OFS    8'h1C
`define FSP_IEN_OFS    8'h20

// Control register fields.
`define FSP_EN_BIT     0
`define FSP_ERS_BIT    1
`define FSP_WRT_BIT    2
`define FSP_REEN_BIT   4
`define FSP_BUSY_BIT   6

// Status, clear and enable register fields.
`define FSP_ST_DONE    0
`define FSP_ST_TMO     1
`define FSP_ST_REJ     2
`define FSP_ST_W       3

// Reset values.
`define FSP_TRIM_PROD  8'h80
`define FSP_PTR_RST    16'h0000
`define FSP_IEN_RST    3'h0

// Flash map, in 16-bit words.
`define FSP_STALLED_READ_SECTION_START 15'h7000
`define FSP_BOOT_END   15'h7FFF
`define FSP_BOOT_11    15'h7E00
`define FSP_BOOT_10    15'h7C00
`define FSP_BOOT_01    15'h7800
`define FSP_BOOT_00    15'h7000

// Timing.
`define FSP_CLK_NS     5
`define FSP_T_MIN_NS   3700000
`define FSP_T_MAX_NS   4500000
`define FSP_TICK_NS    1000
`define FSP_OP_MIN_CYC ((`FSP_T_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_OP_MAX_CYC (`FSP_T_MAX_NS / `FSP_CLK_NS)
`define FSP_TICK_CYC   (`FSP_TICK_NS / `FSP_CLK_NS)
`define FSP_OP_TICKS   (((`FSP_OP_MIN_CYC + `FSP_OP_MAX_CYC) / 2) / `FSP_TICK_CYC)
`define FSP_WINDOW     3'd4

`endif

// ==== hdl/fsp_pkg.sv ====
package fsp_pkg;

   typedef enum logic [1:0] {
      FSP_OP_NONE  = 2'b00,
      FSP_OP_FILL  = 2'b01,
      FSP_OP_ERASE = 2'b10,
      FSP_OP_WRITE = 2'b11
   } fsp_op_e;

   typedef enum logic [1:0] {
      FSP_IDLE  = 2'b00,
      FSP_ARMED = 2'b01,
      FSP_BUSY  = 2'b10
   } fsp_state_e;

   typedef struct packed {
      logic        valid;
      fsp_op_e     op;
      logic [7:0]  page;
      logic [6:0]  word;
      logic [15:0] data;
   } fsp_flash_cmd_s;

   typedef struct packed {
      logic [14:0] boot_start;
      logic [14:0] app_end;
   } fsp_boot_map_s;

endpackage : fsp_pkg

// ==== hdl/fsp_ctrl.sv ====
`include "fsp_regs.svh"

// Function
// (R1) Each erase or page write lasts between 3.7 ms and 4.5 ms.
// (R2) Operation length follows the oscillator trim register.
// (R3) Boot size setting picks 512 to 4096 words, ending at word 0x7FFF.
// (R4) Boot start is 0x7E00/0x7C00/0x7800/0x7000; application ends one word below.
// (R5) Words 0x0000-0x6FFF are the concurrent section, 0x7000-0x7FFF the stalled one.
// (R6) During erase or write only the stalled section is readable.
// (R7) Program counter is 15 bits addressing 16-bit words.
// (R8) Page holds 128 words; PC bits 6:0 word, bits 14:7 page.
// (R9) Pointer bits 15:8 give the page, bits 7:1 the buffer word.
// (R10) Software clears the word part of the pointer for page write.
// (R11) Pointer bit 0 is zero for commands; it selects the byte on reads.
// (R12) Bits written with the enable bit select erase, write, re-enable or fill.
// (R13) Enable bit stays set until the operation ends; software polls it.
// (R14) Software checks the EEPROM write-busy bit before writing control.
// (R15) Software disables interrupts around the control write and store.
// (R16) While the busy flag is set the section is unreadable; re-enable clears it.
// (R17) Software fills the buffer one word per command, pointer stepping by two.
// (R18) A store counts only within four cycles of the control write.
// (R19) Reads of the concurrent section are blocked while it is occupied.
module fsp_ctrl #(
   parameter int unsigned OP_TICKS = `FSP_OP_TICKS
) (
   // Clock and reset.
   input  wire logic                    clock_i,
   input  wire logic                    arst_n_i,
   // APB slave.
   input  wire logic                    psel_i,
   input  wire logic                    penable_i,
   input  wire logic                    pwrite_i,
   input  wire logic [7:0]              paddr_i,
   input  wire logic [31:0]             pwdata_i,
   output logic      [31:0]             prdata_o,
   output logic                         pready_o,
   output logic                         pslverr_o,
   // Fuses and neighbours.
   input  wire logic [1:0]              boot_size_i,
   input  wire logic                    eeprom_write_busy_bit_i,
   // CPU instruction fetch.
   input  wire logic [14:0]             fetch_addr_i,
   output logic                         fetch_stall_o,
   // Flash array and temporary page buffer.
   input  wire logic [15:0]             flash_rdata_i,
   output logic      [14:0]             flash_raddr_o,
   output fsp_pkg::fsp_flash_cmd_s      flash_cmd_o,
   output fsp_pkg::fsp_boot_map_s       boot_map_o,
   // Interrupt.
   output logic                         irq_o
);
   import fsp_pkg::*;

   fsp_state_e              state;
   logic [15:0]             ptr;
   logic [15:0]             wdata;
   logic [7:0]              trim;
   logic [2:0]              cmd_bits;
   logic                    section_busy_flag;
   logic [2:0]              window;
   logic [15:0]             tick_cnt;
   logic [15:0]             tick_period;
   logic [12:0]             op_cnt;
   logic                    op_end;
   logic [`FSP_ST_W-1:0]    stat;
   logic [`FSP_ST_W-1:0]    ien;
   logic [`FSP_ST_W-1:0]    ev;
   logic                    wr_acc;
   logic                    rd_acc;
   logic                    ctrl_wr;
   logic                    store_wr;
   logic                    take_store;
   logic                    win_expire;
   logic                    load_blocked;
   logic [31:0]             next_rdata;
   logic                    next_err;

   assign wr_acc   = psel_i & penable_i & pready_o & pwrite_i;
   assign rd_acc   = psel_i & ~penable_i & ~pwrite_i;
   assign ctrl_wr  = wr_acc & (paddr_i == `FSP_CTRL_OFS);
   assign store_wr = wr_acc & (paddr_i == `FSP_STORE_OFS);
   assign take_store = store_wr & (state == FSP_ARMED) & (window != 3'd0); // see (R18)
   assign win_expire = (state == FSP_ARMED) & ~store_wr & (window == 3'd1); // see (R18)

   // A slower trimmed oscillator stretches each tick and so the whole operation.
   assign tick_period = 16'(`FSP_TICK_CYC) + {8'h00, trim} - {8'h00, `FSP_TRIM_PROD}; // see (R2)
   assign op_end = (state == FSP_BUSY) & (tick_cnt == tick_period - 16'h0001) &
                   (op_cnt == 13'(OP_TICKS - 1)); // see (R1)

   // Reads of the concurrent section return all ones while it is occupied.
   assign load_blocked = section_busy_flag & (flash_raddr_o < `FSP_STALLED_READ_SECTION_START); // see (R16)

   // APB read mux, sampled at the setup cycle and presented in the access cycle.
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      unique case (paddr_i)
         `FSP_CTRL_OFS: begin
            next_rdata[`FSP_EN_BIT]   = (state != FSP_IDLE); // see (R13)
            next_rdata[`FSP_ERS_BIT]  = (state != FSP_IDLE) & cmd_bits[0];
            next_rdata[`FSP_WRT_BIT]  = (state != FSP_IDLE) & cmd_bits[1];
            next_rdata[`FSP_REEN_BIT] = (state != FSP_IDLE) & cmd_bits[2];
            next_rdata[`FSP_BUSY_BIT] = section_busy_flag; // see (R16)
         end
         `FSP_PTR_OFS:   next_rdata[15:0] = ptr;
         `FSP_DATA_OFS:  next_rdata[15:0] = wdata;
         `FSP_STORE_OFS: next_rdata = 32'h0000_0000;
         `FSP_LOAD_OFS: begin
            if (load_blocked) begin
               next_rdata[7:0] = 8'hFF; // see (R19)
            end else begin
               next_rdata[7:0] = ptr[0] ? flash_rdata_i[15:8] : flash_rdata_i[7:0]; // see (R11)
            end
         end
         `FSP_TRIM_OFS:  next_rdata[7:0] = trim;
         `FSP_STAT_OFS:  next_rdata[`FSP_ST_W-1:0] = stat;
         `FSP_CLR_OFS:   next_rdata = 32'h0000_0000;
         `FSP_IEN_OFS:   next_rdata[`FSP_ST_W-1:0] = ien;
         default:        next_err = 1'b1;
      endcase
   end

   // APB handshake: one wait-free access cycle after each setup cycle.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & next_err;
         if (rd_acc) begin
            prdata_o <= next_rdata;
         end else if (!(psel_i & penable_i)) begin
            prdata_o <= 32'h0000_0000;
         end
      end
   end

   // Software-written data registers.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ptr   <= `FSP_PTR_RST;
         wdata <= 16'h0000;
         trim  <= `FSP_TRIM_PROD;
         ien   <= `FSP_IEN_RST;
      end else if (wr_acc) begin
         unique case (paddr_i)
            `FSP_PTR_OFS:  ptr   <= pwdata_i[15:0];
            `FSP_DATA_OFS: wdata <= pwdata_i[15:0];
            `FSP_TRIM_OFS: begin
               if (state != FSP_BUSY) begin
                  trim <= pwdata_i[7:0];
               end
            end
            `FSP_IEN_OFS:  ien   <= pwdata_i[`FSP_ST_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Command sequencer.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state    <= FSP_IDLE;
         cmd_bits <= 3'h0;
         window   <= 3'd0;
      end else begin
         unique case (state)
            FSP_IDLE: begin
               // An EEPROM write in progress locks out self-programming.
               if (ctrl_wr && pwdata_i[`FSP_EN_BIT] && !eeprom_write_busy_bit_i) begin // see (R14)
                  state    <= FSP_ARMED;
                  cmd_bits <= {pwdata_i[`FSP_REEN_BIT], pwdata_i[`FSP_WRT_BIT], pwdata_i[`FSP_ERS_BIT]};
                  window   <= `FSP_WINDOW; // see (R18)
               end
            end
            FSP_ARMED: begin
               window <= window - 3'd1;
               if (take_store) begin
                  if (cmd_bits[0] || cmd_bits[1]) begin
                     state <= FSP_BUSY; // see (R13)
                  end else begin
                     state    <= FSP_IDLE;
                     cmd_bits <= 3'h0;
                  end
               end else if (win_expire) begin
                  state    <= FSP_IDLE;
                  cmd_bits <= 3'h0;
               end
            end
            FSP_BUSY: begin
               if (op_end) begin
                  state    <= FSP_IDLE; // see (R13)
                  cmd_bits <= 3'h0;
               end
            end
            default: begin
               state    <= FSP_IDLE;
               cmd_bits <= 3'h0;
            end
         endcase
      end
   end

   // Oscillator ticks and operation length.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tick_cnt <= 16'h0000;
         op_cnt   <= 13'h0000;
      end else if (state != FSP_BUSY) begin
         tick_cnt <= 16'h0000;
         op_cnt   <= 13'h0000;
      end else if (tick_cnt == tick_period - 16'h0001) begin
         tick_cnt <= 16'h0000;
         op_cnt   <= op_cnt + 13'h0001; // see (R1)
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   // Busy flag for the concurrent section.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         section_busy_flag <= 1'b0;
      end else if (take_store && (cmd_bits[0] || cmd_bits[1])) begin
         section_busy_flag <= 1'b1; // see (R19)
      end else if (take_store && cmd_bits[2]) begin
         section_busy_flag <= 1'b0; // see (R12) (R16)
      end
   end

   // Commands to the flash array and its page buffer.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flash_cmd_o <= '0;
      end else begin
         flash_cmd_o.valid <= 1'b0;
         if (take_store) begin
            flash_cmd_o.valid <= ~cmd_bits[2] | cmd_bits[0] | cmd_bits[1];
            flash_cmd_o.page  <= ptr[15:8]; // see (R9) (R8)
            flash_cmd_o.word  <= ptr[7:1]; // see (R9)
            flash_cmd_o.data  <= wdata;
            if (cmd_bits[0]) begin
               flash_cmd_o.op   <= FSP_OP_ERASE; // see (R12)
               flash_cmd_o.word <= 7'h00;
            end else if (cmd_bits[1]) begin
               flash_cmd_o.op   <= FSP_OP_WRITE; // see (R12)
               flash_cmd_o.word <= 7'h00;
            end else if (cmd_bits[2]) begin
               flash_cmd_o.op <= FSP_OP_NONE;
            end else begin
               flash_cmd_o.op <= FSP_OP_FILL; // see (R12) (R17)
            end
         end
      end
   end

   // Program-memory load address and fetch guarding.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flash_raddr_o <= 15'h0000;
         fetch_stall_o <= 1'b0;
      end else begin
         flash_raddr_o <= ptr[15:1]; // see (R7) (R11)
         fetch_stall_o <= section_busy_flag & (fetch_addr_i < `FSP_STALLED_READ_SECTION_START); // see (R5) (R6) (R19)
      end
   end

   // Boot section map, from the two fuse bits.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boot_map_o.boot_start <= `FSP_BOOT_11;
         boot_map_o.app_end    <= `FSP_BOOT_11 - 15'h0001;
      end else begin
         unique case (boot_size_i)
            2'b11: boot_map_o.boot_start <= `FSP_BOOT_11; // see (R3) (R4)
            2'b10: boot_map_o.boot_start <= `FSP_BOOT_10;
            2'b01: boot_map_o.boot_start <= `FSP_BOOT_01;
            2'b00: boot_map_o.boot_start <= `FSP_BOOT_00;
         endcase
         unique case (boot_size_i)
            2'b11: boot_map_o.app_end <= `FSP_BOOT_11 - 15'h0001; // see (R4)
            2'b10: boot_map_o.app_end <= `FSP_BOOT_10 - 15'h0001;
            2'b01: boot_map_o.app_end <= `FSP_BOOT_01 - 15'h0001;
            2'b00: boot_map_o.app_end <= `FSP_BOOT_00 - 15'h0001;
         endcase
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle.
   always_comb begin
      ev = '0;
      ev[`FSP_ST_DONE] = op_end;
      ev[`FSP_ST_TMO]  = win_expire;
      ev[`FSP_ST_REJ]  = (ctrl_wr && (state != FSP_IDLE || eeprom_write_busy_bit_i)) ||
                         (store_wr && !take_store); // see (R13)
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stat <= '0;
      end else if (wr_acc && paddr_i == `FSP_CLR_OFS) begin
         stat <= (stat & ~pwdata_i[`FSP_ST_W-1:0]) | ev;
      end else begin
         stat <= stat | ev;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |((stat | ev) & ien);
      end
   end

endmodule : fsp_ctrl

// ==== tb/fsp_flash_model.sv ====
module fsp_flash_model (
   // Array read port.
   input  wire logic [14:0] raddr_i,
   output logic      [15:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Each word holds a pattern of its own address, so no two words read the same.
   assign rdata_o = {1'b0, raddr_i} ^ 16'h5A3C;
endmodule : fsp_flash_model

// ==== tb/fsp_ctrl_asserts.sv ====
`include "fsp_regs.svh"

module fsp_ctrl_asserts
   import fsp_pkg::*;
#(
   parameter int unsigned OP_TICKS = 3
) (
   input wire logic             clock_i,
   input wire logic             arst_n_i,
   input wire logic             psel_i,
   input wire logic             penable_i,
   input wire logic             pwrite_i,
   input wire logic [7:0]       paddr_i,
   input wire logic [31:0]      pwdata_i,
   input wire logic             pready_o,
   input wire logic [1:0]       boot_size_i,
   input wire logic [14:0]      fetch_addr_i,
   input wire logic             fetch_stall_o,
   input wire logic [14:0]      flash_raddr_o,
   input fsp_pkg::fsp_flash_cmd_s flash_cmd_o,
   input fsp_pkg::fsp_boot_map_s  boot_map_o,
   input wire logic             irq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic store_q;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_setup;
      psel_i && !penable_i;
   endsequence

   sequence s_wr(logic [7:0] ofs);
      psel_i && penable_i && pready_o && pwrite_i && paddr_i == ofs;
   endsequence

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         store_q <= 1'b0;
      end else begin
         store_q <= psel_i && penable_i && pready_o && pwrite_i && paddr_i == `FSP_STORE_OFS;
      end
   end

   a_ready_after_setup: assert property (s_setup |=> pready_o)
      else $error("no ready in the access cycle");
   a_boot_start_map: assert property ($past(arst_n_i) |->
      boot_map_o.boot_start == 15'(16'h8000 - (16'h1000 >> $past(boot_size_i))))
      else $error("boot start does not match size setting");
   a_app_end_below: assert property (boot_map_o.app_end == boot_map_o.boot_start - 15'h1)
      else $error("application end not one below boot start");
   a_stall_rww_only: assert property (fetch_stall_o |-> $past(fetch_addr_i) < 15'h7000)
      else $error("fetch stalled outside the concurrent section");
   a_cmd_after_store: assert property (flash_cmd_o.valid |-> store_q)
      else $error("flash command without a store");
   a_cmd_single_pulse: assert property (flash_cmd_o.valid |=> !flash_cmd_o.valid)
      else $error("flash command longer than one cycle");
   a_page_word_zero: assert property (flash_cmd_o.valid && flash_cmd_o.op != FSP_OP_FILL |->
      flash_cmd_o.word == 7'h00)
      else $error("page command carries a word address");
   a_ptr_raddr_map: assert property (s_wr(`FSP_PTR_OFS) |=> ##1
      flash_raddr_o == 15'($past(pwdata_i, 2) >> 1))
      else $error("read address not pointer bits 15 to 1");
   a_irq_mask_off: assert property (s_wr(`FSP_IEN_OFS) ##0 pwdata_i[2:0] == 3'h0 |=> ##1 !irq_o)
      else $error("interrupt high with all sources masked");
endmodule : fsp_ctrl_asserts

bind fsp_ctrl fsp_ctrl_asserts #(.OP_TICKS(OP_TICKS)) u_chk (.clock_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .pready_o, .boot_size_i, .fetch_addr_i, .fetch_stall_o, .flash_raddr_o, .flash_cmd_o,
   .boot_map_o, .irq_o);

// ==== tb/test_flash_self_program_control.sv ====
`include "fsp_regs.svh"

module test_flash_self_program_control;
   timeunit 1ns;
   timeprecision 1ps;
   import fsp_pkg::*;

   localparam int unsigned TICKS = 3;

   logic           clock_i                 = 1'b0;
   logic           arst_n_i                = 1'b0;
   logic           psel_i                  = 1'b0;
   logic           penable_i               = 1'b0;
   logic           pwrite_i                = 1'b0;
   logic [7:0]     paddr_i                 = 8'h00;
   logic [31:0]    pwdata_i                = 32'h0;
   logic [1:0]     boot_size_i             = 2'b11;
   logic           eeprom_write_busy_bit_i = 1'b0;
   logic [14:0]    fetch_addr_i            = 15'h7800;
   logic [31:0]    prdata_o, rdq;
   logic           pready_o, pslverr_o, fetch_stall_o, irq_o, rde;
   logic [15:0]    flash_rdata_i;
   logic [14:0]    flash_raddr_o;
   fsp_flash_cmd_s flash_cmd_o, last_cmd;
   fsp_boot_map_s  boot_map_o;
   int             fail_count = 0, n_compared = 0, cyc = 0, n_cmd = 0, t0;

   fsp_ctrl #(.OP_TICKS(TICKS)) u_dut (.clock_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .boot_size_i, .eeprom_write_busy_bit_i, .fetch_addr_i, .fetch_stall_o,
      .flash_rdata_i, .flash_raddr_o, .flash_cmd_o, .boot_map_o, .irq_o);
   fsp_flash_model u_flash (.raddr_i(flash_raddr_o), .rdata_o(flash_rdata_i));

   always #2.5 clock_i = ~clock_i;

   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (flash_cmd_o.valid === 1'b1) begin
         last_cmd <= flash_cmd_o;
         n_cmd    <= n_cmd + 1;
      end
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      rdq = prdata_o;
      rde = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdq, exp);
   endtask : rdc

   // Software sequence: wait for the previous command, then control write and store back to back.
   // The bench raises no interrupt to the core, so interrupts stay off around the sequence.
   task automatic cmd(input logic [7:0] c);
      do apb(1'b0, `FSP_CTRL_OFS, 32'h0); while (rdq[0] !== 1'b0);
      while (eeprom_write_busy_bit_i !== 1'b0) @(posedge clock_i);
      wr(`FSP_CTRL_OFS, {24'h0, c});
      wr(`FSP_STORE_OFS, 32'h0);
   endtask : cmd

   task automatic t_regs;
      rdc(`FSP_TRIM_OFS, 32'h80);
      rdc(`FSP_PTR_OFS, 32'h0);
      rdc(`FSP_STAT_OFS, 32'h0);
      rdc(`FSP_CTRL_OFS, 32'h0);
      apb(1'b0, 8'h24, 32'h0);
      chk(rde, 1'b1);
   endtask : t_regs

   task automatic t_boot;
      for (int i = 0; i < 4; i++) begin
         boot_size_i <= 2'(i);
         repeat (2) @(posedge clock_i);
         chk(boot_map_o, {15'(16'h8000 - (16'h1000 >> i)), 15'(16'h7FFF - (16'h1000 >> i))});
      end
   endtask : t_boot

   task automatic t_refuse;
      int k;
      k = n_cmd;
      wr(`FSP_CTRL_OFS, 32'h01);
      repeat (5) @(posedge clock_i);
      wr(`FSP_STORE_OFS, 32'h0);
      rdc(`FSP_STAT_OFS, 32'h6);
      chk(irq_o, 1'b0);
      wr(`FSP_IEN_OFS, 32'h2);
      repeat (2) @(posedge clock_i);
      chk(irq_o, 1'b1);
      wr(`FSP_CLR_OFS, 32'h7);
      repeat (2) @(posedge clock_i);
      chk(irq_o, 1'b0);
      eeprom_write_busy_bit_i <= 1'b1;
      wr(`FSP_CTRL_OFS, 32'h01);
      rdc(`FSP_STAT_OFS, 32'h4);
      eeprom_write_busy_bit_i <= 1'b0;
      chk(n_cmd, k);
      wr(`FSP_CLR_OFS, 32'h7);
      wr(`FSP_IEN_OFS, 32'h0);
   endtask : t_refuse

   task automatic t_bytes;
      wr(`FSP_PTR_OFS, 32'h7001);
      repeat (2) @(posedge clock_i);
      chk(flash_raddr_o, 15'h3800);
      rdc(`FSP_LOAD_OFS, 32'h62);
      wr(`FSP_PTR_OFS, 32'h7000);
      rdc(`FSP_LOAD_OFS, 32'h3C);
   endtask : t_bytes

   task automatic t_fill;
      wr(`FSP_PTR_OFS, 32'h1200);
      for (int i = 0; i < 2; i++) begin
         wr(`FSP_DATA_OFS, 32'hBE00 + i);
         cmd(8'h01);
         repeat (2) @(posedge clock_i);
         chk(last_cmd, {1'b1, FSP_OP_FILL, 8'h12, 7'(i), 16'(16'hBE00 + i)});
         rdc(`FSP_CTRL_OFS, 32'h0);
         wr(`FSP_PTR_OFS, 32'h1202 + 2 * i);
      end
   endtask : t_fill

   // One erase or page write, with blocking, timing, busy flag and re-enable checked.
   task automatic t_op(input logic [7:0] c, input logic [7:0] trim, input fsp_op_e op);
      int want;
      int k;
      want = TICKS * (72 + trim);
      wr(`FSP_CLR_OFS, 32'h7);
      wr(`FSP_TRIM_OFS, {24'h0, trim});
      wr(`FSP_PTR_OFS, 32'h0500);
      cmd(c);
      t0 = cyc;
      repeat (2) @(posedge clock_i);
      chk(last_cmd[33:16], {1'b1, op, 8'h05, 7'h00});
      rdc(`FSP_CTRL_OFS, {24'h0, 8'h40 | c});
      fetch_addr_i <= 15'h6FFF;
      repeat (2) @(posedge clock_i);
      chk(fetch_stall_o, 1'b1);
      fetch_addr_i <= 15'h7000;
      repeat (2) @(posedge clock_i);
      chk(fetch_stall_o, 1'b0);
      rdc(`FSP_LOAD_OFS, 32'hFF);
      wr(`FSP_CTRL_OFS, 32'h01);
      do apb(1'b0, `FSP_CTRL_OFS, 32'h0); while (rdq[0] !== 1'b0);
      chk(cyc - t0 >= want - 1 && cyc - t0 <= want + 8, 1'b1);
      rdc(`FSP_STAT_OFS, 32'h5);
      rdc(`FSP_CTRL_OFS, 32'h40);
      k = n_cmd;
      cmd(8'h11);
      rdc(`FSP_CTRL_OFS, 32'h0);
      chk(n_cmd, k);
      rdc(`FSP_LOAD_OFS, 32'hBC);
   endtask : t_op

   initial begin
      repeat (20) @(posedge clock_i);
      arst_n_i <= 1'b1;
      t_regs();
      t_boot();
      t_refuse();
      t_bytes();
      t_fill();
      t_op(8'h07, 8'h80, FSP_OP_ERASE);
      t_op(8'h05, 8'h90, FSP_OP_WRITE);
      end_sim();
   end
endmodule : test_flash_self_program_control
